// *** src/lli_regs.svh ***
`ifndef LLI_REGS_SVH
`define LLI_REGS_SVH
// register file index map, 5-bit unified register number
`define LLI_DATA_BASE 5'h00
`define LLI_PTR_BASE 5'h08
`define LLI_SP_IDX 5'h0E
`define LLI_FP_IDX 5'h0F
`define LLI_IDX_BASE 5'h10
`define LLI_MOD_BASE 5'h14
// word access step and offset limits in bytes
`define LLI_WORD_STEP 32'h0000_0004
`define LLI_SMALL_OFS_MAX 17'h0003C
`define LLI_LARGE_OFS_MAX 17'h1FFFC
`define LLI_FRAME_OFS_MIN 17'h00004
`define LLI_FRAME_OFS_MAX 17'h00080
// reset values
`define LLI_REG_RESET 32'h0000_0000
`define LLI_ACC_RESET 40'h00_0000_0000
`endif

// *** src/lli_pkg.sv ***
package lli_pkg;
  typedef enum logic [4:0] {
    LLI_LDI_LOW = 5'b00000,
    LLI_LDI_HIGH = 5'b00001,
    LLI_LDI_ZERO = 5'b00010,
    LLI_LDI_SHORT = 5'b00011,
    LLI_LDI_LONG = 5'b00100,
    LLI_CLR_ACC0 = 5'b00101,
    LLI_CLR_ACC1 = 5'b00110,
    LLI_CLR_BOTH = 5'b00111,
    LLI_LD_IND = 5'b01000,
    LLI_LD_INC = 5'b01001,
    LLI_LD_DEC = 5'b01010,
    LLI_LD_SMALL = 5'b01011,
    LLI_LD_LADD = 5'b01100,
    LLI_LD_LSUB = 5'b01101,
    LLI_LD_PIDX = 5'b01110,
    LLI_LD_FRAME = 5'b01111,
    LLI_LD_IREG = 5'b10000,
    LLI_LD_IINC = 5'b10001,
    LLI_LD_IDEC = 5'b10010,
    LLI_LD_IMOD = 5'b10011
  } lli_op_type;

  typedef enum logic [0:0] {
    LLI_IDLE = 1'b0,
    LLI_WAIT = 1'b1
  } lli_state_type;

  function automatic logic lli_is_data(input logic [4:0] r);
    return r[4:3] == 2'h0;
  endfunction
  function automatic logic lli_is_ptr(input logic [4:0] r);
    return r[4:3] == 2'h1;
  endfunction
  function automatic logic lli_is_idx(input logic [4:0] r);
    return r[4:2] == 3'h4;
  endfunction
  function automatic logic lli_is_mod(input logic [4:0] r);
    return r[4:2] == 3'h5;
  endfunction
endpackage

// *** src/lli_decode.sv ***
`timescale 1ns/100ps
`include "lli_regs.svh"
module lli_decode
  import lli_pkg::*;
(
  // instruction fields
  input wire lli_op_type i_op,
  input wire logic [4:0] i_dest,
  input wire logic [4:0] i_src,
  input wire logic [4:0] i_index,
  input wire logic [16:0] i_offset,
  input wire logic i_parallel,
  // classification
  output logic o_legal,
  output logic o_is_load,
  output logic o_len32
);
  logic dest_dp;
  logic word_ofs;

  always_comb
  begin
    dest_dp = lli_is_data(i_dest) | lli_is_ptr(i_dest);
    word_ofs = i_offset[1:0] == 2'h0;
    o_legal = 1'b1;
    o_is_load = 1'b1;
    o_len32 = 1'b0;
    unique case (i_op)
      // any register half or whole register is a target
      LLI_LDI_LOW, LLI_LDI_HIGH, LLI_LDI_ZERO, LLI_LDI_LONG:
      begin
        o_is_load = 1'b0;
        o_len32 = 1'b1;
      end
      // short constant only into data or pointer registers
      LLI_LDI_SHORT:
      begin
        o_is_load = 1'b0;
        o_legal = dest_dp;
      end
      LLI_CLR_ACC0, LLI_CLR_ACC1, LLI_CLR_BOTH:
      begin
        o_is_load = 1'b0;
        o_len32 = 1'b1;
      end
      // source is any pointer including stack and frame pointer
      LLI_LD_IND:
        o_legal = dest_dp & lli_is_ptr(i_src);
      // same register loaded and post-modified is undefined
      LLI_LD_INC, LLI_LD_DEC:
        o_legal = dest_dp & lli_is_ptr(i_src) & (i_dest != i_src);
      LLI_LD_SMALL:
        o_legal = dest_dp & lli_is_ptr(i_src) & word_ofs &
                  (i_offset <= `LLI_SMALL_OFS_MAX);
      LLI_LD_LADD, LLI_LD_LSUB:
      begin
        o_len32 = 1'b1;
        o_legal = dest_dp & lli_is_ptr(i_src) & word_ofs &
                  (i_offset <= `LLI_LARGE_OFS_MAX);
      end
      LLI_LD_PIDX:
        o_legal = lli_is_data(i_dest) & lli_is_ptr(i_src) &
                  lli_is_ptr(i_index);
      LLI_LD_FRAME:
        o_legal = dest_dp & word_ofs &
                  (i_offset >= `LLI_FRAME_OFS_MIN) &
                  (i_offset <= `LLI_FRAME_OFS_MAX);
      // index register sources for data loads
      LLI_LD_IREG, LLI_LD_IINC, LLI_LD_IDEC:
        o_legal = lli_is_data(i_dest) & lli_is_idx(i_src);
      LLI_LD_IMOD:
        o_legal = lli_is_data(i_dest) & lli_is_idx(i_src) &
                  lli_is_mod(i_index);
      default:
        o_legal = 1'b0;
    endcase
    // immediates never pair; long loads never pair
    if (i_parallel && (o_len32 || !o_is_load))
    begin
      o_legal = 1'b0;
    end
  end
endmodule // lli_decode

// *** src/lli_agen.sv ***
`timescale 1ns/100ps
`include "lli_regs.svh"
module lli_agen
  import lli_pkg::*;
(
  // operands
  input wire lli_op_type i_op,
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_index_val,
  input wire logic [16:0] i_offset,
  input wire logic i_same_index,
  // results
  output logic [31:0] o_addr,
  output logic [31:0] o_post_val,
  output logic o_post_en,
  output logic o_misaligned
);
  logic [31:0] ofs;

  always_comb
  begin
    ofs = {15'h0000, i_offset};
    o_addr = i_base;
    o_post_val = i_base;
    o_post_en = 1'b0;
    unique case (i_op)
      LLI_LD_SMALL, LLI_LD_LADD:
        o_addr = i_base + ofs;
      LLI_LD_LSUB, LLI_LD_FRAME:
        o_addr = i_base - ofs;
      // access old address, then step by one word
      LLI_LD_INC, LLI_LD_IINC:
      begin
        o_post_val = i_base + `LLI_WORD_STEP;
        o_post_en = 1'b1;
      end
      LLI_LD_DEC, LLI_LD_IDEC:
      begin
        o_post_val = i_base - `LLI_WORD_STEP;
        o_post_en = 1'b1;
      end
      // add second source after the access
      LLI_LD_PIDX, LLI_LD_IMOD:
      begin
        o_post_val = i_base + i_index_val;
        // a common pointer for both operands gives a plain load
        o_post_en = !i_same_index;
      end
      default:
        o_post_en = 1'b0;
    endcase
    // low two bits of the pre-modify address
    o_misaligned = o_addr[1:0] != 2'h0;
  end
endmodule // lli_agen

// *** src/lli_core.sv ***
// What this block does
// - half-register immediate writes 16 bits, other half kept.
// - half loads target data, pointer, index, modifier, base, length.
// - zero-extended form puts 16 bits low and clears upper bits.
// - sign-extended forms copy constant sign into upper bits.
// - short form is 7-bit signed, data or pointer targets only.
// - long signed form is 16-bit, into any register.
// - accumulators only cleared, singly or both together.
// - short immediate and all loads except large-offset forms 16-bit, others 32-bit.
// - immediate loads never issue in parallel.
// - pointer load reads a word at a pointer address.
// - word loads need address multiple of 4, else misaligned fault.
// - post inc/dec use old address then step pointer by 4.
// - small offset 0..60 added, pointer unchanged.
// - large offset 0..131068 added or subtracted.
// - frame form subtracts 4..128 from the frame pointer.
// - destination equal to post-modified pointer is undefined.
// - 16-bit loads may pair, 32-bit loads issue alone.
// - sources are six pointers plus stack and frame pointer.
// - data loads also take index registers with modify forms.
// - register-indexed form loads then adds second source.
// - data load writes a full word into a data register.
`timescale 1ns/100ps
`include "lli_regs.svh"
module lli_core
  import lli_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // instruction issue
  input wire logic i_issue_valid,
  input wire lli_op_type i_issue_op,
  input wire logic [4:0] i_issue_dest,
  input wire logic [4:0] i_issue_src,
  input wire logic [4:0] i_issue_index,
  input wire logic [15:0] i_issue_const,
  input wire logic [16:0] i_issue_offset,
  input wire logic i_issue_parallel,
  output logic o_ready,
  // data memory load path
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // accumulator writes from the arithmetic side
  input wire logic [1:0] i_acc_wr,
  input wire logic [39:0] i_acc_wdata,
  // completion and exceptions
  output logic o_done,
  output logic o_len32,
  output logic o_undef_exc,
  output logic o_misalign_exc,
  // register readback
  input wire logic [4:0] i_rd_sel,
  output logic [31:0] o_rd_data,
  output logic [39:0] o_acc0,
  output logic [39:0] o_acc1
);
  logic [31:0] regs_ff [32];
  lli_state_type state_ff;
  lli_state_type nxt_state;
  logic ready_ff;
  logic req_ff;
  logic [31:0] addr_ff;
  logic done_ff;
  logic len32_ff;
  logic undef_ff;
  logic misalign_ff;
  logic [31:0] rd_data_ff;
  logic [39:0] acc0_ff;
  logic [39:0] acc1_ff;
  logic [4:0] ld_dest_ff;
  logic [4:0] upd_reg_ff;
  logic upd_en_ff;
  logic [31:0] upd_val_ff;

  logic take;
  logic legal;
  logic is_load;
  logic len32;
  logic [4:0] base_sel;
  logic [31:0] base_val;
  logic [31:0] ea;
  logic [31:0] post_val;
  logic post_en;
  logic misaligned;
  logic imm_wr;
  logic [31:0] imm_val;
  logic ld_go;
  logic ack_fin;
  logic [15:0] c;

  lli_decode u_decode (
    .i_op(i_issue_op),
    .i_dest(i_issue_dest),
    .i_src(i_issue_src),
    .i_index(i_issue_index),
    .i_offset(i_issue_offset),
    .i_parallel(i_issue_parallel),
    .o_legal(legal),
    .o_is_load(is_load),
    .o_len32(len32)
  );

  lli_agen u_agen (
    .i_op(i_issue_op),
    .i_base(base_val),
    .i_index_val(regs_ff[i_issue_index]),
    .i_offset(i_issue_offset),
    .i_same_index(i_issue_index == i_issue_src),
    .o_addr(ea),
    .o_post_val(post_val),
    .o_post_en(post_en),
    .o_misaligned(misaligned)
  );

  // frame form always addresses from the frame pointer
  assign base_sel = (i_issue_op == LLI_LD_FRAME) ? `LLI_FP_IDX
                                                 : i_issue_src;
  assign base_val = regs_ff[base_sel];
  assign take = i_issue_valid && (state_ff == LLI_IDLE);
  assign c = i_issue_const;
  assign imm_wr = take && legal && !is_load &&
                  (i_issue_op <= LLI_LDI_LONG);
  // a faulting load never starts, so nothing is written
  assign ld_go = take && legal && is_load && !misaligned;
  assign ack_fin = (state_ff == LLI_WAIT) && i_mem_ack;

  always_comb
  begin
    imm_val = regs_ff[i_issue_dest];
    unique case (i_issue_op)
      // low half replaced, high half intact
      LLI_LDI_LOW:
        imm_val = {regs_ff[i_issue_dest][31:16], c};
      LLI_LDI_HIGH:
        imm_val = {c, regs_ff[i_issue_dest][15:0]};
      LLI_LDI_ZERO:
        imm_val = {16'h0000, c};
      LLI_LDI_SHORT:
        imm_val = {{25{c[6]}}, c[6:0]};
      LLI_LDI_LONG:
        imm_val = {{16{c[15]}}, c};
      default:
        imm_val = regs_ff[i_issue_dest];
    endcase
  end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      LLI_IDLE:
        if (ld_go)
        begin
          nxt_state = LLI_WAIT;
        end
      LLI_WAIT:
        if (i_mem_ack)
        begin
          nxt_state = LLI_IDLE;
        end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_ff <= LLI_IDLE;
      ready_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_state == LLI_IDLE;
    end
  end

  // register file; the load result is written last so it wins
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int i = 0; i < 32; i++)
      begin
        regs_ff[i] <= `LLI_REG_RESET;
      end
    end
    else
    begin
      if (imm_wr)
      begin
        regs_ff[i_issue_dest] <= imm_val;
      end
      if (ack_fin)
      begin
        // pointer modified only after the access
        if (upd_en_ff)
        begin
          regs_ff[upd_reg_ff] <= upd_val_ff;
        end
        regs_ff[ld_dest_ff] <= i_mem_rdata;
      end
    end
  end

  // captured at issue so the pointer update uses the old value
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ld_dest_ff <= 5'h00;
      upd_reg_ff <= 5'h00;
      upd_en_ff <= 1'b0;
      upd_val_ff <= `LLI_REG_RESET;
    end
    else if (ld_go)
    begin
      ld_dest_ff <= i_issue_dest;
      upd_reg_ff <= base_sel;
      upd_en_ff <= post_en;
      upd_val_ff <= post_val;
    end
  end

  // memory request held until acknowledged
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      req_ff <= 1'b0;
      addr_ff <= `LLI_REG_RESET;
    end
    else if (ld_go)
    begin
      req_ff <= 1'b1;
      addr_ff <= ea;
    end
    else if (ack_fin)
    begin
      req_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      done_ff <= 1'b0;
      undef_ff <= 1'b0;
      misalign_ff <= 1'b0;
      len32_ff <= 1'b0;
    end
    else
    begin
      done_ff <= (take && legal && !is_load) || ack_fin;
      undef_ff <= take && !legal;
      misalign_ff <= take && legal && is_load && misaligned;
      if (take)
      begin
        len32_ff <= len32;
      end
    end
  end

  // instructions only write zero to the accumulators; the instruction beats a write
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc0_ff <= `LLI_ACC_RESET;
      acc1_ff <= `LLI_ACC_RESET;
    end
    else
    begin
      if (take && (i_issue_op == LLI_CLR_ACC0 ||
                   i_issue_op == LLI_CLR_BOTH) && legal)
        acc0_ff <= `LLI_ACC_RESET;
      else if (i_acc_wr[0])
        acc0_ff <= i_acc_wdata;
      if (take && (i_issue_op == LLI_CLR_ACC1 ||
                   i_issue_op == LLI_CLR_BOTH) && legal)
        acc1_ff <= `LLI_ACC_RESET;
      else if (i_acc_wr[1])
        acc1_ff <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rd_data_ff <= `LLI_REG_RESET;
    else
      rd_data_ff <= regs_ff[i_rd_sel];
  end

  assign o_ready = ready_ff;
  assign o_mem_req = req_ff;
  assign o_mem_addr = addr_ff;
  assign o_done = done_ff;
  assign o_len32 = len32_ff;
  assign o_undef_exc = undef_ff;
  assign o_misalign_exc = misalign_ff;
  assign o_rd_data = rd_data_ff;
  assign o_acc0 = acc0_ff;
  assign o_acc1 = acc1_ff;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  chk_low_half_keep: assert property (
    take && legal && i_issue_op == LLI_LDI_LOW |=>
      regs_ff[$past(i_issue_dest)] ==
      {$past(regs_ff[i_issue_dest][31:16]), $past(i_issue_const)})
    else $error("low half load disturbed the high half");
  chk_zero_extend: assert property (
    take && legal && i_issue_op == LLI_LDI_ZERO |=>
      regs_ff[$past(i_issue_dest)][31:16] == 16'h0000)
    else $error("zero extended load left upper bits set");
  chk_short_sign: assert property (
    take && legal && i_issue_op == LLI_LDI_SHORT |=>
      regs_ff[$past(i_issue_dest)] ==
      {{25{$past(i_issue_const[6])}}, $past(i_issue_const[6:0])})
    else $error("short signed constant wrongly extended");
  chk_acc_both: assert property (
    take && legal && i_issue_op == LLI_CLR_BOTH |=>
      acc0_ff == 40'h0 && acc1_ff == 40'h0)
    else $error("accumulators not both cleared");
  chk_pair_refused: assert property (
    take && i_issue_parallel && !is_load |=> o_undef_exc && !o_done)
    else $error("paired immediate load not refused");
  chk_addr_aligned: assert property (
    o_mem_req |-> o_mem_addr[1:0] == 2'h0)
    else $error("misaligned address reached memory");
  chk_fault_silent: assert property (
    take && legal && is_load && misaligned |=>
      o_misalign_exc && !o_mem_req ##1 !o_mem_req)
    else $error("faulting load started an access");
  chk_post_step: assert property (
    ld_go && i_issue_op == LLI_LD_INC |=>
      o_mem_addr == $past(base_val) &&
      upd_val_ff == $past(base_val) + `LLI_WORD_STEP)
    else $error("post increment address or step wrong");
  chk_same_reg: assert property (
    take && i_issue_op == LLI_LD_DEC && i_issue_dest == i_issue_src
      |=> o_undef_exc && state_ff == LLI_IDLE)
    else $error("load into its own post-modified pointer ran");
  chk_req_hold: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("memory request dropped before acknowledge");
endmodule // lli_core

// *** dv/lli_mem_model.sv ***
`timescale 1ns/100ps
module lli_mem_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // load path from the core
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [2:0] i_delay,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [2:0] wait_ff;

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wait_ff <= 3'h0;
      o_ack <= 1'b0;
      o_rdata <= 32'hA5A5_A5A5;
    end
    else if (i_req && !o_ack && wait_ff >= i_delay)
    begin
      wait_ff <= 3'h0;
      o_ack <= 1'b1;
      o_rdata <= {i_addr[15:0], ~i_addr[31:16]} ^ 32'h5A5A_C3C3;
    end
    else
    begin
      // data is only good with the answer, so scramble it otherwise
      wait_ff <= (i_req && !o_ack) ? wait_ff + 3'h1 : 3'h0;
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule // lli_mem_model

// *** dv/tb_load_immediate_and_load_unit.sv ***
`timescale 1ns/100ps
module tb_load_immediate_and_load_unit
  import lli_pkg::*;
;
  logic i_clock, i_arst_n, i_issue_valid, i_issue_parallel, o_ready;
  lli_op_type i_issue_op;
  logic [4:0] i_issue_dest, i_issue_src, i_issue_index, i_rd_sel;
  logic [15:0] i_issue_const;
  logic [16:0] i_issue_offset;
  logic o_mem_req, i_mem_ack, o_done, o_len32, o_undef_exc;
  logic o_misalign_exc, saw_req;
  logic [31:0] o_mem_addr, i_mem_rdata, o_rd_data, req_addr;
  logic [1:0] i_acc_wr;
  logic [39:0] i_acc_wdata, o_acc0, o_acc1;
  logic [2:0] mem_delay;
  logic [31:0] sh [32];
  int miscompares, num_checks;

  lli_core lli_core_inst (.i_clock, .i_arst_n, .i_issue_valid, .i_issue_op,
    .i_issue_dest, .i_issue_src, .i_issue_index, .i_issue_const,
    .i_issue_offset, .i_issue_parallel, .o_ready, .o_mem_req, .o_mem_addr,
    .i_mem_ack, .i_mem_rdata, .i_acc_wr, .i_acc_wdata, .o_done, .o_len32,
    .o_undef_exc, .o_misalign_exc, .i_rd_sel, .o_rd_data, .o_acc0, .o_acc1);
  lli_mem_model lli_mem_model_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_req(o_mem_req), .i_addr(o_mem_addr), .i_delay(mem_delay),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  always #5 i_clock = ~i_clock;

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[15:0], ~a[31:16]} ^ 32'h5A5A_C3C3;
  endfunction

  function automatic logic [31:0] imm_val(input lli_op_type op,
    input logic [31:0] old, input logic [15:0] k);
    case (op)
      LLI_LDI_LOW: return {old[31:16], k};
      LLI_LDI_HIGH: return {k, old[15:0]};
      LLI_LDI_ZERO: return {16'h0000, k};
      LLI_LDI_SHORT: return {{25{k[6]}}, k[6:0]};
      default: return {{16{k[15]}}, k};
    endcase
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [39:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_res(input string what, input logic [1:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // outcome: 0 done, 1 undefined, 2 misaligned
  task automatic run_op(input lli_op_type op, input logic [4:0] d, s, x,
    input logic [15:0] k, input logic [16:0] f, input logic par,
    output logic [1:0] res);
    int n;
    @(posedge i_clock);
    i_issue_valid <= 1'b1;
    {i_issue_dest, i_issue_src, i_issue_index} <= {d, s, x};
    {i_issue_const, i_issue_offset, i_issue_parallel} <= {k, f, par};
    i_issue_op <= op;
    mem_delay <= 3'($urandom_range(0, 5));
    @(posedge i_clock);
    i_issue_valid <= 1'b0;
    saw_req = 1'b0;
    res = 2'h3;
    for (n = 0; n < 40 && res == 2'h3; n++)
    begin
      #1;
      if (o_mem_req === 1'b1)
      begin
        saw_req = 1'b1;
        req_addr = o_mem_addr;
        chk_val("busy ready", 40'h0, {39'h0, o_ready});
      end
      if (o_done === 1'b1)
        res = 2'h0;
      else if (o_undef_exc === 1'b1)
        res = 2'h1;
      else if (o_misalign_exc === 1'b1)
        res = 2'h2;
      else
        @(posedge i_clock);
    end
    if (res == 2'h3)
    begin
      miscompares++;
      give_verdict();
    end
    chk_val("idle ready", 40'h1, {39'h0, o_ready});
  endtask

  task automatic chk_reg(input string what, input logic [4:0] r);
    @(posedge i_clock);
    i_rd_sel <= r;
    @(posedge i_clock);
    #1;
    chk_val(what, {8'h00, sh[r]}, {8'h00, o_rd_data});
  endtask

  task automatic do_imm(input lli_op_type op, input logic [4:0] d,
    input logic [15:0] k, input logic par);
    logic [1:0] res, e;
    e = {1'b0, par | (op == LLI_LDI_SHORT && d[4])};
    run_op(op, d, 5'h00, 5'h00, k, 17'h00000, par, res);
    chk_res("imm outcome", e, res); // refusals
    if (e == 2'h0)
    begin
      sh[d] = imm_val(op, sh[d], k);
      chk_val("imm length", {39'h0, op != LLI_LDI_SHORT},
        {39'h0, o_len32});
    end
    chk_reg("imm target", d); // values
  endtask

  task automatic set_reg(input logic [4:0] r, input logic [31:0] v);
    do_imm(LLI_LDI_LOW, r, v[15:0], 1'b0); // low half
    do_imm(LLI_LDI_HIGH, r, v[31:16], 1'b0); // high half
  endtask

  task automatic do_load(input lli_op_type op, input logic [4:0] d, s, x,
    input logic [16:0] f, input logic par, bad);
    logic [31:0] b, a, p;
    logic [1:0] res, e;
    logic upd, big;
    b = sh[s];
    big = op inside {LLI_LD_LADD, LLI_LD_LSUB};
    a = (op inside {LLI_LD_SMALL, LLI_LD_LADD}) ? b + 32'(f) :
      (op inside {LLI_LD_LSUB, LLI_LD_FRAME}) ? b - 32'(f) : b;
    upd = op inside {LLI_LD_INC, LLI_LD_IINC, LLI_LD_DEC, LLI_LD_IDEC,
      LLI_LD_IMOD} || (op == LLI_LD_PIDX && x != s);
    p = (op inside {LLI_LD_INC, LLI_LD_IINC}) ? b + 32'h0000_0004 :
      (op inside {LLI_LD_DEC, LLI_LD_IDEC}) ? b - 32'h0000_0004 : b + sh[x];
    e = bad ? 2'h1 : (a[1:0] != 2'h0) ? 2'h2 : 2'h0;
    run_op(op, d, s, x, 16'h0000, f, par, res);
    chk_res("load outcome", e, res); // faults
    chk_val("load request", {39'h0, e == 2'h0}, {39'h0, saw_req});
    if (e == 2'h0)
    begin
      chk_val("load address", {8'h00, a}, {8'h00, req_addr});
      sh[d] = mem_word(a);
      if (upd)
        sh[s] = p;
      chk_val("load length", {39'h0, big}, {39'h0, o_len32}); // length
    end
    chk_reg("load target", d); // target
    chk_reg("load pointer", s); // update
  endtask

  initial
  begin
    lli_op_type op;
    logic [4:0] d, s, x;
    logic [16:0] f;
    logic [31:0] w;
    logic [39:0] v;
    logic [1:0] res;
    logic par;
    {i_clock, i_arst_n, i_issue_valid, i_issue_parallel, i_acc_wr} = '0;
    {i_issue_dest, i_issue_src, i_issue_index, i_rd_sel} = '0;
    {i_issue_const, i_issue_offset, i_acc_wdata, mem_delay} = '0;
    i_issue_op = LLI_LDI_LOW;
    foreach (sh[i])
      sh[i] = 32'h0000_0000;
    void'($urandom(32'h8124));
    repeat (16) @(posedge i_clock);
    i_arst_n <= 1'b1;
    do_imm(LLI_LDI_SHORT, 5'h01, 16'h0040, 1'b0); // lowest
    do_imm(LLI_LDI_SHORT, 5'h09, 16'h003F, 1'b0); // highest
    do_imm(LLI_LDI_SHORT, 5'h10, 16'h0005, 1'b0); // bad target
    do_imm(LLI_LDI_LONG, 5'h1C, 16'h8000, 1'b0); // lowest
    do_imm(LLI_LDI_ZERO, 5'h14, 16'hFFFF, 1'b0); // all ones
    for (int i = 0; i < 40; i++)
      do_imm(lli_op_type'(5'($urandom_range(0, 4))), 5'($urandom),
        16'($urandom), $urandom_range(0, 7) == 0); // mix
    $display("test immediates done");
    for (int i = 0; i < 4; i++)
    begin
      v = {8'($urandom), 32'($urandom)};
      @(posedge i_clock);
      {i_acc_wr, i_acc_wdata} <= {2'h3, v};
      @(posedge i_clock);
      i_acc_wr <= 2'h0;
      op = (i == 3) ? LLI_CLR_BOTH : lli_op_type'(5'h05 + 5'(i));
      run_op(op, 5'h00, 5'h00, 5'h00, 16'h0000, 17'h00000, i == 3, res);
      chk_res("clear outcome", {1'b0, i == 3}, res); // pairing
      chk_val("clear length", 40'h1, {39'h0, o_len32});
      chk_val("acc zero", (i == 0 || i == 2) ? 40'h0 : v, o_acc0);
      chk_val("acc one", (i == 1 || i == 2) ? 40'h0 : v, o_acc1);
    end
    $display("test clears done");
    set_reg(5'h0A, 32'h0000_3002);
    do_load(LLI_LD_DEC, 5'h03, 5'h0A, 5'h00, 17'h0, 1'b0, 1'b0);
    set_reg(5'h0A, 32'h0000_3000);
    set_reg(5'h0F, 32'h0000_8000);
    do_load(LLI_LD_INC, 5'h0A, 5'h0A, 5'h00, 17'h0, 1'b0, 1'b1);
    do_load(LLI_LD_DEC, 5'h0A, 5'h0A, 5'h00, 17'h0, 1'b0, 1'b1);
    do_load(LLI_LD_SMALL, 5'h03, 5'h0A, 5'h00, 17'h3C, 1'b0, 1'b0);
    do_load(LLI_LD_SMALL, 5'h03, 5'h0A, 5'h00, 17'h40, 1'b0, 1'b1);
    do_load(LLI_LD_SMALL, 5'h03, 5'h0A, 5'h00, 17'h06, 1'b0, 1'b1);
    do_load(LLI_LD_LADD, 5'h03, 5'h0A, 5'h00, 17'h1FFFC, 1'b0, 1'b0);
    do_load(LLI_LD_LSUB, 5'h03, 5'h0A, 5'h00, 17'h1FFFC, 1'b1, 1'b1);
    do_load(LLI_LD_IND, 5'h03, 5'h0A, 5'h00, 17'h0, 1'b1, 1'b0);
    do_load(LLI_LD_FRAME, 5'h03, 5'h0F, 5'h00, 17'h80, 1'b0, 1'b0);
    do_load(LLI_LD_FRAME, 5'h03, 5'h0F, 5'h00, 17'h04, 1'b0, 1'b0);
    do_load(LLI_LD_FRAME, 5'h03, 5'h0F, 5'h00, 17'h00, 1'b0, 1'b1);
    do_load(LLI_LD_FRAME, 5'h03, 5'h0F, 5'h00, 17'h84, 1'b0, 1'b1);
    do_load(LLI_LD_PIDX, 5'h03, 5'h0A, 5'h0A, 17'h0, 1'b0, 1'b0);
    do_load(LLI_LD_IND, 5'h03, 5'h01, 5'h00, 17'h0, 1'b0, 1'b1);
    $display("test load corners done");
    for (int i = 0; i < 48; i++)
    begin
      op = lli_op_type'(5'h08 + 5'($urandom_range(0, 11)));
      s = (op >= LLI_LD_IREG) ? 5'h10 + 5'($urandom_range(0, 3)) :
        (op == LLI_LD_FRAME) ? 5'h0F : 5'h08 + 5'($urandom_range(0, 7));
      x = (op == LLI_LD_IMOD) ? 5'h14 + 5'($urandom_range(0, 3)) : s ^ 5'h01;
      // register-indexed form only loads data registers
      d = (op >= LLI_LD_IREG || op == LLI_LD_PIDX || s[0]) ?
        5'($urandom_range(0, 7)) : s ^ 5'h02;
      f = (op == LLI_LD_SMALL) ? 17'($urandom_range(0, 15)) << 2 :
        (op == LLI_LD_FRAME) ? 17'($urandom_range(1, 32)) << 2 :
        (op inside {LLI_LD_LADD, LLI_LD_LSUB}) ?
        17'($urandom_range(0, 32767)) << 2 : 17'h0;
      w = $urandom;
      w[1:0] = ($urandom_range(0, 5) == 0) ? 2'h1 : 2'h0;
      set_reg(s, w);
      if (op inside {LLI_LD_PIDX, LLI_LD_IMOD})
        set_reg(x, $urandom & 32'hFFFF_FFFC);
      par = $urandom_range(0, 3) == 0;
      do_load(op, d, s, x, f, par,
        par && op inside {LLI_LD_LADD, LLI_LD_LSUB});
    end
    $display("test random loads done");
    give_verdict();
  end
endmodule // tb_load_immediate_and_load_unit
